// ==== inc/pwm_out_pkg.sv ====
`default_nettype none
package pwm_out_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] alt_dead_time_off      = 8'h00;
    localparam logic [7:0] trigger_control_off    = 8'h04;
    localparam logic [7:0] output_pin_control_off = 8'h08;
    localparam logic [7:0] primary_trig_cmp_off   = 8'h0c;
    localparam logic [7:0] fault_limit_control_off = 8'h10;
    localparam logic [7:0] module_control_off     = 8'h14;
    localparam logic [7:0] block_status_off       = 8'h18;
    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] reg_reset_val         = 16'h0000;
    localparam logic [15:0] alt_dead_time_mask    = 16'h3fff;
    localparam logic [15:0] trigger_control_mask  = 16'hf0bf;
    localparam logic [15:0] trig_cmp_mask         = 16'hfff8;
    // ------------------------------------------------------------
    // output_pin_control fields
    // ------------------------------------------------------------
    localparam int high_pin_ownership_bit  = 15;
    localparam int low_pin_ownership_bit   = 14;
    localparam int high_pin_polarity_bit   = 13;
    localparam int low_pin_polarity_bit    = 12;
    localparam int pin_pair_mode_lsb       = 10;
    localparam int high_override_enable_bit = 9;
    localparam int low_override_enable_bit = 8;
    localparam int override_data_lsb       = 6;
    localparam int fault_state_data_lsb    = 4;
    localparam int limit_state_data_lsb    = 2;
    localparam int swap_bit                = 1;
    localparam int override_sync_bit       = 0;
    // ------------------------------------------------------------
    // fault_limit_control fields
    // ------------------------------------------------------------
    localparam int indep_fault_mode_bit    = 15;
    localparam int limit_source_select_lsb = 10;
    localparam int limit_polarity_bit      = 9;
    localparam int limit_enable_bit        = 8;
    localparam int fault_source_select_lsb = 3;
    localparam int fault_polarity_bit      = 2;
    localparam int fault_mode_lsb          = 0;
    // ------------------------------------------------------------
    // module_control and block_status fields
    // ------------------------------------------------------------
    localparam int module_enable_bit       = 0;
    localparam int fault_held_bit          = 0;
    // ------------------------------------------------------------
    // source select codes and modes
    // ------------------------------------------------------------
    localparam logic [4:0] first_fault_code = 5'h08;
    localparam logic [4:0] reserved_code    = 5'h1f;
    localparam logic [1:0] pmode_complementary = 2'h0;
    localparam logic [1:0] pmode_redundant     = 2'h1;
    localparam logic [1:0] pmode_push_pull     = 2'h2;
    localparam logic [1:0] pmode_independent   = 2'h3;
    localparam logic [1:0] fmode_latched    = 2'h0;
    localparam logic [1:0] fmode_cycle      = 2'h1;
endpackage : pwm_out_pkg
`default_nettype wire

// ==== hdl/pwm_output_fault_trigger_ctrl.sv ====
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1: alternate dead time holds 14 bits; bits 15-14 read zero.
// RQ2: a secondary generator never raises the trigger interrupt.
// RQ3: pin pair mode picks independent, push-pull, redundant or complementary outputs.
// RQ4: normal mode fault forces high to fault data 1, low to 0.
// RQ5: independent mode: limit forces high only, fault forces low only.
// RQ6: normal mode limit forces high and low from limit data bits.
// RQ7: independent mode ignores limit data bits entirely.
// RQ8: forced values are logical; pin polarity converts them to levels.
// RQ9: swap exchanges the generated high and low signals between pins.
// RQ10: with override sync set, override changes apply at period boundary.
// RQ11: with override sync clear, override changes apply next clock.
// RQ12: time base equal to trigger compare issues an ADC trigger.
// RQ13: limit source codes pick comparators 1-4 or faults 1-23.
// RQ14: selected limit source also drives dead time compensation input.
// RQ15: fault source select uses same encoding; 11111 reserved.
// RQ16: limit polarity set means selected source is active low.
// RQ17: limit enable clear means the limit source has no effect; the code still feeds it to dead_time_comp_input and block_status.
// RQ18: software changes pin mode only while module is disabled.
// RQ19: software changes polarity bits only while module is disabled.
// RQ20: software avoids sharing fault 1 in independent mode.
// RQ21: fault mode 11 disables, 01 cycle by cycle, 00 latched.
// RQ22: fault polarity set means selected fault source active low.
// RQ23: ownership bit gives the pin to PWM, else to GPIO.
// RQ24: override enable drives the pin from override data.
// RQ25: fault and limit forcing outrank override and normal waveform.
module pwm_output_fault_trigger_ctrl #(
    parameter int  num_faults   = 23,
    parameter int  num_comps    = 4,
    parameter bit  is_secondary = 1'b0
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // generator side
    input  wire logic        gen_high,
    input  wire logic        gen_low,
    input  wire logic [15:0] time_base,
    input  wire logic        period_boundary,
    // comparator and fault pins
    input  wire logic [num_comps-1:0]  comp_in,
    input  wire logic [num_faults-1:0] fault_in,
    // power stage pins
    output logic             high_output,
    output logic             high_output_en,
    output logic             low_output,
    output logic             low_output_en,
    // other units
    output logic             adc_trigger,
    output logic             trigger_irq,
    output logic             dead_time_comp_input,
    output logic [13:0]      alt_dead_time
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (num_faults != 23 || num_comps != 4) begin : g_bad
        $error("pwm_output_fault_trigger_ctrl: unsupported source count");
    end

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    function automatic logic pick_src(input logic [4:0] code,
                                      input logic [num_comps-1:0] c,
                                      input logic [num_faults-1:0] f);
        logic [4:0] idx;
        idx = code - pwm_out_pkg::first_fault_code;
        if (code < 5'h04)
            pick_src = c[code[1:0]];
        else if (code >= pwm_out_pkg::first_fault_code && code != pwm_out_pkg::reserved_code)
            pick_src = f[idx];
        else
            pick_src = 1'b0;
    endfunction : pick_src

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] alt_dt_q, trig_ctl_q, pin_ctl_q, trig_cmp_q, flt_ctl_q;
    logic        enable_q, fault_hold_q, pp_phase_q, trig_q, irq_q;
    logic [1:0]  ovr_dat_eff_q;
    logic        ovr_en_h_eff_q, ovr_en_l_eff_q;
    logic        high_q, low_q;
    logic [31:0] prdata_q;
    logic [num_comps+num_faults-1:0] sync1_q, sync2_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup   = psel & ~penable;
    wire access  = psel & penable;
    wire hit_adt = paddr == pwm_out_pkg::alt_dead_time_off;
    wire hit_tcl = paddr == pwm_out_pkg::trigger_control_off;
    wire hit_pin = paddr == pwm_out_pkg::output_pin_control_off;
    wire hit_cmp = paddr == pwm_out_pkg::primary_trig_cmp_off;
    wire hit_flt = paddr == pwm_out_pkg::fault_limit_control_off;
    wire hit_mod = paddr == pwm_out_pkg::module_control_off;
    wire hit_sts = paddr == pwm_out_pkg::block_status_off;
    wire hit_any = hit_adt | hit_tcl | hit_pin | hit_cmp | hit_flt | hit_mod | hit_sts;
    wire wr      = access & pwrite & hit_any;
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;
    assign prdata  = prdata_q;

    // ------------------------------------------------------------
    // field views
    // ------------------------------------------------------------
    wire [num_comps-1:0]  comp_s  = sync2_q[num_comps-1:0];
    wire [num_faults-1:0] fault_s = sync2_q[num_comps+num_faults-1:num_comps];
    wire [1:0] pmode   = pin_ctl_q[pwm_out_pkg::pin_pair_mode_lsb +: 2];
    wire [1:0] fd      = pin_ctl_q[pwm_out_pkg::fault_state_data_lsb +: 2];
    wire [1:0] ld      = pin_ctl_q[pwm_out_pkg::limit_state_data_lsb +: 2];
    wire [1:0] fmode   = flt_ctl_q[pwm_out_pkg::fault_mode_lsb +: 2];
    wire       indep   = flt_ctl_q[pwm_out_pkg::indep_fault_mode_bit];
    wire       override_sync   = pin_ctl_q[pwm_out_pkg::override_sync_bit];
    wire       pol_h   = pin_ctl_q[pwm_out_pkg::high_pin_polarity_bit];
    wire       pol_l   = pin_ctl_q[pwm_out_pkg::low_pin_polarity_bit];
    wire [4:0] cl_code = flt_ctl_q[pwm_out_pkg::limit_source_select_lsb +: 5];
    wire [4:0] ft_code = flt_ctl_q[pwm_out_pkg::fault_source_select_lsb +: 5];

    // ------------------------------------------------------------
    // fault and current limit detection
    // ------------------------------------------------------------
    wire cl_src   = pick_src(cl_code, comp_s, fault_s);             // RQ13
    wire ft_src   = pick_src(ft_code, comp_s, fault_s);             // RQ15
    wire cl_act   = cl_src ^ flt_ctl_q[pwm_out_pkg::limit_polarity_bit];   // RQ16
    wire ft_act   = ft_src ^ flt_ctl_q[pwm_out_pkg::fault_polarity_bit];   // RQ22
    wire cl_on    = flt_ctl_q[pwm_out_pkg::limit_enable_bit] & cl_act;     // RQ17
    wire ft_mode_on = (fmode == pwm_out_pkg::fmode_latched) | (fmode == pwm_out_pkg::fmode_cycle);
    wire ft_on    = ft_mode_on & (ft_act | fault_hold_q);           // RQ21
    wire sts_clr  = wr & hit_sts & pwdata[pwm_out_pkg::fault_held_bit];
    wire hold_clr = (fmode == pwm_out_pkg::fmode_cycle) ? period_boundary : sts_clr;
    wire hold_d   = ft_mode_on & (ft_act | (fault_hold_q & ~hold_clr));
    assign dead_time_comp_input = cl_src;                           // RQ14

    // ------------------------------------------------------------
    // output path
    // ------------------------------------------------------------
    logic gen_h, gen_l;
    always_comb begin
        unique case (pmode)                                         // RQ3
            pwm_out_pkg::pmode_complementary: begin
                gen_h = gen_high;
                gen_l = ~gen_high;
            end
            pwm_out_pkg::pmode_redundant: begin
                gen_h = gen_high;
                gen_l = gen_high;
            end
            pwm_out_pkg::pmode_push_pull: begin
                gen_h = gen_high & pp_phase_q;
                gen_l = gen_high & ~pp_phase_q;
            end
            pwm_out_pkg::pmode_independent: begin
                gen_h = gen_high;
                gen_l = gen_low;
            end
        endcase
    end
    wire run_h  = enable_q & gen_h;
    wire run_l  = enable_q & gen_l;
    wire swap   = pin_ctl_q[pwm_out_pkg::swap_bit];
    wire sw_h   = swap ? run_l : run_h;                             // RQ9
    wire sw_l   = swap ? run_h : run_l;                             // RQ9
    wire ovr_h  = ovr_en_h_eff_q ? ovr_dat_eff_q[1] : sw_h;        // RQ24
    wire ovr_l  = ovr_en_l_eff_q ? ovr_dat_eff_q[0] : sw_l;        // RQ24
    wire log_h  = indep ? (cl_on ? fd[1] : ovr_h)                   // RQ5 RQ7 RQ25
                        : (ft_on ? fd[1] : cl_on ? ld[1] : ovr_h);  // RQ4 RQ6 RQ25
    wire log_l  = indep ? (ft_on ? fd[0] : ovr_l)                   // RQ5 RQ7 RQ25
                        : (ft_on ? fd[0] : cl_on ? ld[0] : ovr_l);  // RQ4 RQ6 RQ25
    wire pin_h  = log_h ^ pol_h;                                    // RQ8
    wire pin_l  = log_l ^ pol_l;                                    // RQ8
    wire ovr_load = ~override_sync | period_boundary;                       // RQ10 RQ11
    wire trig_hit = time_base == (trig_cmp_q & pwm_out_pkg::trig_cmp_mask);   // RQ12

    assign high_output    = high_q;
    assign low_output     = low_q;
    assign high_output_en = pin_ctl_q[pwm_out_pkg::high_pin_ownership_bit];  // RQ23
    assign low_output_en  = pin_ctl_q[pwm_out_pkg::low_pin_ownership_bit];   // RQ23
    assign adc_trigger    = trig_q;
    assign trigger_irq    = irq_q;
    assign alt_dead_time  = alt_dt_q[13:0];

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [15:0] sts_word = {12'h000, cl_src, ft_on, cl_on, fault_hold_q};
    wire [15:0] rd_word =
        hit_adt ? (alt_dt_q & pwm_out_pkg::alt_dead_time_mask) :    // RQ1
        hit_tcl ? trig_ctl_q :
        hit_pin ? pin_ctl_q :
        hit_cmp ? (trig_cmp_q & pwm_out_pkg::trig_cmp_mask) :
        hit_flt ? flt_ctl_q :
        hit_mod ? {15'h0000, enable_q} :
        hit_sts ? sts_word : 16'h0000;

    // ------------------------------------------------------------
    // sequential logic
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {fault_in, comp_in};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_dt_q   <= pwm_out_pkg::reg_reset_val;
            trig_ctl_q <= pwm_out_pkg::reg_reset_val;
            pin_ctl_q  <= pwm_out_pkg::reg_reset_val;
            trig_cmp_q <= pwm_out_pkg::reg_reset_val;
            flt_ctl_q  <= pwm_out_pkg::reg_reset_val;
            enable_q   <= 1'b0;
        end else begin
            if (wr && hit_adt) alt_dt_q <= pwdata[15:0] & pwm_out_pkg::alt_dead_time_mask; // RQ1
            if (wr && hit_tcl) trig_ctl_q <= pwdata[15:0] & pwm_out_pkg::trigger_control_mask;
            if (wr && hit_pin) pin_ctl_q <= pwdata[15:0];
            if (wr && hit_cmp) trig_cmp_q <= pwdata[15:0] & pwm_out_pkg::trig_cmp_mask; // RQ12
            if (wr && hit_flt) flt_ctl_q <= pwdata[15:0];
            if (wr && hit_mod) enable_q <= pwdata[pwm_out_pkg::module_enable_bit];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_dat_eff_q  <= 2'h0;
            ovr_en_h_eff_q <= 1'b0;
            ovr_en_l_eff_q <= 1'b0;
        end else if (ovr_load) begin                                // RQ10 RQ11
            ovr_dat_eff_q  <= pin_ctl_q[pwm_out_pkg::override_data_lsb +: 2];
            ovr_en_h_eff_q <= pin_ctl_q[pwm_out_pkg::high_override_enable_bit];
            ovr_en_l_eff_q <= pin_ctl_q[pwm_out_pkg::low_override_enable_bit];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_hold_q <= 1'b0;
            pp_phase_q   <= 1'b1;
            high_q       <= 1'b0;
            low_q        <= 1'b0;
            trig_q       <= 1'b0;
            irq_q        <= 1'b0;
            prdata_q     <= 32'h0000_0000;
        end else begin
            fault_hold_q <= hold_d;                                 // RQ21
            if (period_boundary) pp_phase_q <= ~pp_phase_q;         // RQ3
            high_q       <= pin_h;
            low_q        <= pin_l;
            trig_q       <= trig_hit;                               // RQ12
            irq_q        <= trig_hit & ~is_secondary;               // RQ2
            if (setup) prdata_q <= {16'h0000, rd_word};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    alt_dt_upper_a: assert property ( // RQ1
        access && !pwrite && hit_adt |-> prdata[15:14] == 2'b00)
        else $error("alternate dead time upper bits not zero");

    sec_no_irq_a: assert property ( // RQ2
        trigger_irq |-> adc_trigger && !is_secondary)
        else $error("secondary generator raised trigger interrupt");

    fault_force_a: assert property ( // RQ4
        !indep && ft_on |=> high_output == ($past(fd[1]) ^ $past(pol_h))
                            && low_output == ($past(fd[0]) ^ $past(pol_l)))
        else $error("fault data not forced on outputs");

    indep_limit_a: assert property ( // RQ5
        indep && cl_on |=> high_output == ($past(fd[1]) ^ $past(pol_h)))
        else $error("independent limit did not force high output");

    limit_force_a: assert property ( // RQ6
        !indep && cl_on && !ft_on |=> low_output == ($past(ld[0]) ^ $past(pol_l)))
        else $error("limit data not forced on low output");

    trig_match_a: assert property ( // RQ12
        presetn |=> adc_trigger == $past(trig_hit))
        else $error("adc trigger does not follow compare match");

    ovr_sync_hold_a: assert property ( // RQ10
        override_sync && !period_boundary |=> $stable(ovr_dat_eff_q))
        else $error("synchronised override changed off boundary");

    ovr_now_a: assert property ( // RQ11
        !override_sync |=> ovr_dat_eff_q == $past(pin_ctl_q[pwm_out_pkg::override_data_lsb +: 2]))
        else $error("unsynchronised override not applied next clock");

    limit_off_a: assert property ( // RQ17
        !flt_ctl_q[pwm_out_pkg::limit_enable_bit] |-> !cl_on)
        else $error("limit active while limit mode disabled");

    fault_off_a: assert property ( // RQ21
        fmode == 2'h3 |-> !ft_on ##1 !fault_hold_q)
        else $error("fault acted while fault input disabled");

    ovr_drive_a: assert property ( // RQ24
        ovr_en_h_eff_q && !ft_on && !cl_on
            |=> high_output == ($past(ovr_dat_eff_q[1]) ^ $past(pol_h)))
        else $error("override data not on high pin");

    swap_high_a: assert property ( // RQ9
        swap && !ovr_en_h_eff_q && !ft_on && !cl_on
            |=> high_output == ($past(run_l) ^ $past(pol_h)))
        else $error("swap not applied to high pin");

    fault_first_a: assert property ( // RQ25
        !indep && ft_on && cl_on |=> high_output == ($past(fd[1]) ^ $past(pol_h)))
        else $error("limit data outranked fault data");

    reserved_src_a: assert property ( // RQ13
        cl_code == pwm_out_pkg::reserved_code |-> !dead_time_comp_input)
        else $error("reserved limit source selected a signal");

    redundant_a: assert property ( // RQ3
        pmode == pwm_out_pkg::pmode_redundant |-> gen_h == gen_l)
        else $error("redundant mode outputs differ");

    push_pull_a: assert property ( // RQ3
        pmode == pwm_out_pkg::pmode_push_pull |-> !(gen_h && gen_l))
        else $error("push-pull mode drove both outputs");

    fault_seen_c: cover property (!indep && ft_on ##1 ft_on);
    limit_seen_c: cover property (indep && cl_on);
    trig_seen_c:  cover property (adc_trigger);
    swap_seen_c:  cover property (swap && enable_q && gen_high);
endmodule : pwm_output_fault_trigger_ctrl
`default_nettype wire

// ==== dv/pwm_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// fault sources and power stage
// ------------------------------------------------------------
module pwm_stage_model (
    // clock
    input  wire logic        pclk,
    // requested source levels
    input  wire logic [3:0]  comp_req,
    input  wire logic [22:0] fault_req,
    // driven pin levels and enables
    input  wire logic        hi_drv,
    input  wire logic        hi_en,
    input  wire logic        lo_drv,
    input  wire logic        lo_en,
    // source pins
    output logic [3:0]       comp_in,
    output logic [22:0]      fault_in,
    // pin levels, pulled low when released
    output logic             hi_pin,
    output logic             lo_pin
);
    // sources change just after the edge, like real pins
    always_ff @(posedge pclk) begin
        comp_in  <= comp_req;
        fault_in <= fault_req;
    end
    assign hi_pin = hi_en ? hi_drv : 1'b0;
    assign lo_pin = lo_en ? lo_drv : 1'b0;
endmodule : pwm_stage_model
`default_nettype wire

// ==== dv/pwm_output_fault_trigger_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_output_fault_trigger_ctrl_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        gen_high = 1, gen_low = 0, period_boundary = 0, err;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] time_base = 0;
    logic [3:0]  comp_req = 0, comp_in;
    logic [22:0] fault_req = 0, fault_in;
    logic [13:0] alt_dead_time;
    logic        pready, pslverr, high_output, high_output_en, low_output, low_output_en;
    logic        adc_trigger, trigger_irq, dead_time_comp_input, hi_pin, lo_pin;
    int          failures = 0, check_count = 0;
    always #2.5 pclk = ~pclk;
    pwm_output_fault_trigger_ctrl pwm_output_fault_trigger_ctrl_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gen_high, .gen_low,
        .time_base, .period_boundary, .comp_in, .fault_in, .high_output, .high_output_en,
        .low_output, .low_output_en, .adc_trigger, .trigger_irq, .dead_time_comp_input,
        .alt_dead_time);
    pwm_stage_model pwm_stage_model_i (.pclk, .comp_req, .fault_req, .hi_drv(high_output),
        .hi_en(high_output_en), .lo_drv(low_output), .lo_en(low_output_en), .comp_in,
        .fault_in, .hi_pin, .lo_pin);
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task report_and_stop;
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) begin
            psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        end
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task cfg(input logic [7:0] a, input logic [15:0] v);
        apb(1, pwm_out_pkg::module_control_off, 0);
        apb(1, a, {16'h0000, v});
        apb(1, pwm_out_pkg::module_control_off, 1);
    endtask : cfg
    task pins(input logic h, input logic l);
        repeat (4) @(posedge pclk);
        #1;
        chk("hi_pin", hi_pin, h);
        chk("lo_pin", lo_pin, l);
    endtask : pins
    task pulse_b;
        @(posedge pclk) period_boundary <= 1;
        @(posedge pclk) period_boundary <= 0;
    endtask : pulse_b
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_regs;
        for (int i = 0; i < 7; i++) begin
            apb(0, 8'(i * 4), 0);
            chk("reset_val", rd, 0);
        end
        apb(1, pwm_out_pkg::alt_dead_time_off, 32'hffffffff);
        apb(0, pwm_out_pkg::alt_dead_time_off, 0);
        chk("alt_rd", rd, 32'h00003fff);
        chk("alt_port", alt_dead_time, 14'h3fff);
        apb(1, pwm_out_pkg::primary_trig_cmp_off, 32'hffffffff);
        apb(0, pwm_out_pkg::primary_trig_cmp_off, 0);
        chk("cmp_rd", rd, 32'h0000fff8);
        apb(0, 8'h1c, 0);
        chk("slverr", err, 1);
        chk("unmapped", rd, 0);
    endtask : t_regs
    task t_trig;
        apb(1, pwm_out_pkg::primary_trig_cmp_off, 32'h00000128);
        @(posedge pclk) time_base <= 16'h0128;
        @(posedge pclk) time_base <= 16'h0000;
        #1 chk("adc_trig", adc_trigger, 1);
        chk("trig_irq", trigger_irq, 1);
        @(posedge pclk) #1 chk("adc_end", adc_trigger, 0);
    endtask : t_trig
    task t_pins;
        cfg(pwm_out_pkg::output_pin_control_off, 16'hcc00);
        pins(1, 0);
        cfg(pwm_out_pkg::output_pin_control_off, 16'hcc02);
        pins(0, 1);
        cfg(pwm_out_pkg::output_pin_control_off, 16'hec00);
        pins(0, 0);
        @(posedge pclk) gen_low <= 1;
        cfg(pwm_out_pkg::output_pin_control_off, 16'hc000);
        pins(1, 0);
        @(posedge pclk) gen_low <= 0;
        cfg(pwm_out_pkg::output_pin_control_off, 16'hc400);
        pins(1, 1);
        cfg(pwm_out_pkg::output_pin_control_off, 16'hc800);
        pins(1, 0);
        pulse_b;
        pins(0, 1);
        apb(1, pwm_out_pkg::output_pin_control_off, 16'hcfc0);
        repeat (2) @(posedge pclk);
        #1 chk("ovr_now", {hi_pin, lo_pin}, 2'b11);
        apb(1, pwm_out_pkg::output_pin_control_off, 16'hcf41);
        pins(1, 1);
        pulse_b;
        pins(0, 1);
        cfg(pwm_out_pkg::output_pin_control_off, 16'h0000);
        chk("own", {high_output_en, low_output_en}, 2'b00);
    endtask : t_pins
    task t_fault;
        cfg(pwm_out_pkg::output_pin_control_off, 16'hcf20);
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h0041);
        pins(0, 0);
        @(posedge pclk) fault_req[0] <= 1;
        pins(1, 0);
        @(posedge pclk) fault_req[0] <= 0;
        pins(1, 0);
        pulse_b;
        pins(0, 0);
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h0045);
        pins(1, 0);
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h0047);
        pins(0, 0);
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h0040);
        @(posedge pclk) fault_req[0] <= 1;
        @(posedge pclk) fault_req[0] <= 0;
        pulse_b;
        pins(1, 0);
        apb(1, pwm_out_pkg::block_status_off, 32'h00000001);
        pins(0, 0);
    endtask : t_fault
    task t_limit;
        cfg(pwm_out_pkg::output_pin_control_off, 16'hcc14);
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h0103);
        pins(1, 0);
        @(posedge pclk) comp_req[0] <= 1;
        pins(0, 1);
        chk("dtc", dead_time_comp_input, 1);
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h0003);
        pins(1, 0);
        @(posedge pclk) comp_req[0] <= 0;
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h0303);
        pins(0, 1);
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h8303);
        pins(0, 0);
        cfg(pwm_out_pkg::fault_limit_control_off, 16'h8141);
        @(posedge pclk) fault_req[0] <= 1;
        pins(1, 1);
        @(posedge pclk) fault_req[0] <= 0;
    endtask : t_limit
    task t_codes;
        logic r;
        for (int i = 0; i < 32; i++) begin
            r = (i inside {[4:7], 31});
            cfg(pwm_out_pkg::fault_limit_control_off, {1'b0, 5'(i), 10'h100});
            @(posedge pclk) begin
                comp_req <= (r || i > 3) ? {4{r}} : 4'(1 << i);
                fault_req <= (r || i < 8) ? {23{r}} : 23'(1 << (i - 8));
            end
            pins(0, 1);
            chk("dtc_code", dead_time_comp_input, !r);
        end
    endtask : t_codes
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_trig;
        t_pins;
        t_fault;
        t_limit;
        t_codes;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        report_and_stop;
    end
endmodule : pwm_output_fault_trigger_ctrl_test
`default_nettype wire
